/* hw/cgc_pkg.sv */
// package for the converter global control block: register map, field layout, codes
// assumes a 32-bit classic wishbone slave with word-aligned registers
package cgc_pkg;

    // register byte addresses (offsets chosen for this block)
    localparam logic [7:0] CTL_ADDR     = 8'h00;
    localparam logic [7:0] RESULT_ADDR  = 8'h04;
    localparam logic [7:0] STATUS_ADDR  = 8'h08;
    localparam logic [7:0] MASK_ADDR    = 8'h0c;

    // control field positions
    localparam int XDIV_LSB  = 9;
    localparam int LP_BIT    = 8;
    localparam int PRE_LSB   = 6;
    localparam int SSEL_LSB  = 4;
    localparam int VMID_BIT  = 3;
    localparam int REFON_BIT = 2;
    localparam int OVIE_BIT  = 1;

    localparam logic [15:0] CTL_RESET    = 16'h0000;
    // writable bits: 11..1; bits 15..12 and bit 0 read zero
    localparam logic [15:0] CTL_WR_MASK  = 16'h0ffe;

    // status / mask bits
    localparam int ST_DONE_BIT = 0;
    localparam int ST_OVF_BIT  = 1;
    localparam logic [1:0] ST_RESET = 2'h0;

    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        CGC_SRC_MAIN,
        CGC_SRC_SUB,
        CGC_SRC_AUX,
        CGC_SRC_TIMER
    } cgc_src_t;

endpackage : cgc_pkg

/* hw/cgc_clkdiv.sv */
// cascaded divider: prescaler then extended divider, emits one-cycle ticks
// assumes src_tick_i is a one-cycle pulse per edge of the selected source
`timescale 1ns/1ps
module cgc_clkdiv
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       src_tick_i,
    input  wire logic [1:0] pre_sel_i,
    input  wire logic [2:0] xdiv_sel_i,
    output logic            tick_o
);
    typedef struct packed
    {
        logic [2:0] pre_cnt;
        logic [5:0] x_cnt;
        logic       tick;
    } cgc_div_t;

    cgc_div_t s_r;
    cgc_div_t s_nxt;

    // ratio of the extended divider; reserved codes fall back to /1
    function automatic logic [5:0] xratio(input logic [2:0] sel);
        unique case (sel)
            3'h1:    xratio = 6'h03;
            3'h2:    xratio = 6'h10;
            3'h3:    xratio = 6'h30;
            default: xratio = 6'h01;
        endcase
    endfunction : xratio

    logic [2:0] pre_last;
    logic       pre_tick;

    always_comb
    begin
        pre_last = 3'((4'h1 << pre_sel_i) - 4'h1);
        pre_tick = src_tick_i && (s_r.pre_cnt >= pre_last);
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (src_tick_i)
        begin
            s_nxt.pre_cnt = pre_tick ? 3'h0 : s_r.pre_cnt + 3'h1;
        end
        if (pre_tick)
        begin
            if (s_r.x_cnt >= xratio(xdiv_sel_i) - 6'h01)
            begin
                s_nxt.x_cnt = 6'h00;
                s_nxt.tick  = 1'b1;
            end
            else
            begin
                s_nxt.x_cnt = s_r.x_cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;

    tick_gap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_r.tick && pre_sel_i == 2'h1 && xdiv_sel_i == 3'h1 && $stable(pre_sel_i)
        |=> !s_r.tick) else $error("divided tick repeated back to back");
    unity_div_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        src_tick_i && pre_sel_i == 2'h0 && xdiv_sel_i == 3'h0
        |=> s_r.tick) else $error("divide by one lost a tick");

endmodule : cgc_clkdiv

/* hw/cgc_srcsel.sv */
// source clock selector: turns the chosen source level into an edge tick
// assumes source clock levels are synchronous samples, well below SYS_CLK_I
`timescale 1ns/1ps
module cgc_srcsel
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic [3:0] src_lvl_i,
    input  wire logic [1:0] sel_i,
    output logic            tick_o
);
    typedef struct packed
    {
        logic prev;
        logic tick;
    } cgc_sel_t;

    cgc_sel_t s_r;
    cgc_sel_t s_nxt;
    logic     cur;

    always_comb
    begin
        cur = src_lvl_i[sel_i];
        s_nxt.prev = cur;
        s_nxt.tick = cur && !s_r.prev;
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;

    src_edge_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(src_lvl_i[sel_i]) && $stable(sel_i) |=> s_r.tick)
        else $error("rising edge of chosen source missed");

endmodule : cgc_srcsel

/* hw/cgc_top.sv */
// converter global control: register, clock chain, analog enables, overflow irq
// assumes a classic wishbone master; analog side delivers results as pulses
`timescale 1ns/1ps
module cgc_top
(
    input  wire logic        SYS_CLK_I,
    input  wire logic        NRST_I,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        SUB_MAIN_CLOCK_I,
    input  wire logic        AUX_CLOCK_I,
    input  wire logic        TIMER_EXTERNAL_CLOCK_IN_I,
    input  wire logic        GLOBAL_IRQ_ENABLE_I,
    input  wire logic        RESULT_VALID_I,
    input  wire logic [15:0] RESULT_DATA_I,
    output logic             CONV_CLK_TICK_O,
    output logic             LOW_POWER_SELECT_O,
    output logic             MIDSUPPLY_BUFFER_ON_O,
    output logic             REFERENCE_GENERATOR_ON_O,
    output logic             OVERFLOW_IRQ_O,
    output logic             IRQ_O
);
    typedef struct packed
    {
        logic [15:0] ctl;
        logic [15:0] result;
        logic        unread;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [31:0] dat;
        logic        ack;
        logic        lp;
        logic        vmid;
        logic        refon;
        logic        ovf_irq;
        logic        irq;
    } cgc_state_t;

    cgc_state_t s_r;
    cgc_state_t s_nxt;

    logic       src_tick;
    logic       div_tick;
    logic [3:0] src_lvl;
    logic       bus_req;
    logic       wr_lo;
    logic       wr_hi;

    // the main source is the system clock itself: a tick on every cycle
    assign src_lvl = {TIMER_EXTERNAL_CLOCK_IN_I, AUX_CLOCK_I, SUB_MAIN_CLOCK_I, 1'b0};

    logic [3:0] src_lvl_eff;
    logic       main_sel;
    logic       sel_tick;
    assign main_sel = s_r.ctl[cgc_pkg::SSEL_LSB +: 2] == cgc_pkg::CGC_SRC_MAIN;
    assign src_lvl_eff = src_lvl;
    assign src_tick = main_sel ? 1'b1 : sel_tick;

    cgc_srcsel u_srcsel
    (
        .clk_i     (SYS_CLK_I),
        .nrst_i    (NRST_I),
        .src_lvl_i (src_lvl_eff),
        .sel_i     (s_r.ctl[cgc_pkg::SSEL_LSB +: 2]),
        .tick_o    (sel_tick)
    );

    cgc_clkdiv u_clkdiv
    (
        .clk_i      (SYS_CLK_I),
        .nrst_i     (NRST_I),
        .src_tick_i (src_tick),
        .pre_sel_i  (s_r.ctl[cgc_pkg::PRE_LSB +: 2]),
        .xdiv_sel_i (s_r.ctl[cgc_pkg::XDIV_LSB +: 3]),
        .tick_o     (div_tick)
    );

    // low-power mode halves the converter rate by dropping every other tick
    logic lp_phase_r;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            lp_phase_r <= 1'b0;
        end
        else if (div_tick)
        begin
            lp_phase_r <= ~lp_phase_r;
        end
    end

    logic conv_tick_r;
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            conv_tick_r <= 1'b0;
        end
        else
        begin
            conv_tick_r <= div_tick && (!s_r.lp || lp_phase_r);
        end
    end
    assign CONV_CLK_TICK_O = conv_tick_r;

    assign bus_req = WB_CYC_I && WB_STB_I && !s_r.ack;
    assign wr_lo   = bus_req && WB_WE_I && WB_SEL_I[0];
    assign wr_hi   = bus_req && WB_WE_I && WB_SEL_I[1];

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.ack = bus_req;
        // control register: byte lanes 0 and 1, reserved bits forced to zero
        if (WB_ADR_I == cgc_pkg::CTL_ADDR)
        begin
            if (wr_lo)
            begin
                s_nxt.ctl[7:0] = WB_DAT_I[7:0] & cgc_pkg::CTL_WR_MASK[7:0];
            end
            if (wr_hi)
            begin
                s_nxt.ctl[15:8] = WB_DAT_I[15:8] & cgc_pkg::CTL_WR_MASK[15:8];
            end
        end
        if (WB_ADR_I == cgc_pkg::MASK_ADDR && wr_lo)
        begin
            s_nxt.mask = WB_DAT_I[1:0];
        end
        // read data is captured with ack
        s_nxt.dat = cgc_pkg::UNMAPPED_DATA;
        if (bus_req && !WB_WE_I)
        begin
            unique case (WB_ADR_I)
                cgc_pkg::CTL_ADDR:    s_nxt.dat = {16'h0000, s_r.ctl & cgc_pkg::CTL_WR_MASK};
                cgc_pkg::RESULT_ADDR: s_nxt.dat = {16'h0000, s_r.result};
                cgc_pkg::STATUS_ADDR: s_nxt.dat = {30'h0, s_r.status};
                cgc_pkg::MASK_ADDR:   s_nxt.dat = {30'h0, s_r.mask};
                default:              s_nxt.dat = cgc_pkg::UNMAPPED_DATA;
            endcase
        end
        // reading the result releases it; reading status clears it
        if (bus_req && !WB_WE_I && WB_ADR_I == cgc_pkg::RESULT_ADDR)
        begin
            s_nxt.unread = 1'b0;
        end
        if (bus_req && !WB_WE_I && WB_ADR_I == cgc_pkg::STATUS_ADDR)
        begin
            s_nxt.status = cgc_pkg::ST_RESET;
        end
        // a new result wins over a same-cycle read and clear
        if (RESULT_VALID_I)
        begin
            s_nxt.result = RESULT_DATA_I;
            s_nxt.unread = 1'b1;
            s_nxt.status[cgc_pkg::ST_DONE_BIT] = 1'b1;
            if (s_r.unread)
            begin
                s_nxt.status[cgc_pkg::ST_OVF_BIT] = 1'b1;
            end
        end
        s_nxt.lp    = s_nxt.ctl[cgc_pkg::LP_BIT];
        s_nxt.vmid  = s_nxt.ctl[cgc_pkg::VMID_BIT];
        s_nxt.refon = s_nxt.ctl[cgc_pkg::REFON_BIT];
        s_nxt.ovf_irq = s_nxt.status[cgc_pkg::ST_OVF_BIT]
                        && s_nxt.ctl[cgc_pkg::OVIE_BIT] && GLOBAL_IRQ_ENABLE_I;
        s_nxt.irq   = |(s_nxt.status & s_nxt.mask);
    end

    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            s_r     <= '0;
            s_r.ctl <= cgc_pkg::CTL_RESET;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign WB_DAT_O                 = s_r.dat;
    assign WB_ACK_O                 = s_r.ack;
    assign LOW_POWER_SELECT_O       = s_r.lp;
    assign MIDSUPPLY_BUFFER_ON_O    = s_r.vmid;
    assign REFERENCE_GENERATOR_ON_O = s_r.refon;
    assign OVERFLOW_IRQ_O           = s_r.ovf_irq;
    assign IRQ_O                    = s_r.irq;

    reserved_zero_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_r.ctl[15:12] == 4'h0 && !s_r.ctl[0])
        else $error("reserved control bits not zero");
    ctl_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        wr_lo && WB_ADR_I == cgc_pkg::CTL_ADDR
        |=> s_r.ctl[7:0] == ($past(WB_DAT_I[7:0]) & 8'hfe))
        else $error("control low byte write lost");
    lp_follow_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_r.lp == s_r.ctl[cgc_pkg::LP_BIT])
        else $error("low-power output disagrees with control");
    vmid_follow_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        MIDSUPPLY_BUFFER_ON_O == s_r.ctl[cgc_pkg::VMID_BIT])
        else $error("midsupply buffer output wrong");
    ref_follow_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        REFERENCE_GENERATOR_ON_O == s_r.ctl[cgc_pkg::REFON_BIT])
        else $error("reference output wrong");
    ovf_gate_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        OVERFLOW_IRQ_O |-> s_r.ctl[cgc_pkg::OVIE_BIT] && $past(GLOBAL_IRQ_ENABLE_I))
        else $error("overflow irq raised while disabled");
    ovf_set_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        RESULT_VALID_I && s_r.unread |=> s_r.status[cgc_pkg::ST_OVF_BIT])
        else $error("overwrite of unread result not flagged");
    lp_rate_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_r.lp && div_tick && !lp_phase_r |=> !conv_tick_r)
        else $error("low-power mode passed a dropped tick");
    ack_drop_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for more than one cycle");

    // bus side: the answer is a fixed single wait state, data is zero outside ack
    ack_answer_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        bus_req |=> WB_ACK_O)
        else $error("bus request not answered");
    dat_idle_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data not zero outside ack");

    // upper control byte: divider and low-power fields, reserved nibble dropped
    ctl_hi_write_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        wr_hi && WB_ADR_I == cgc_pkg::CTL_ADDR
        |=> s_r.ctl[15:8] == ($past(WB_DAT_I[15:8]) & 8'h0f))
        else $error("control high byte write lost");
    mask_write_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        wr_lo && WB_ADR_I == cgc_pkg::MASK_ADDR
        |=> s_r.mask == $past(WB_DAT_I[1:0]))
        else $error("mask write lost");

    // a status read with no new result in the same cycle leaves nothing set
    status_clear_a: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        bus_req && !WB_WE_I && WB_ADR_I == cgc_pkg::STATUS_ADDR && !RESULT_VALID_I
        |=> s_r.status == 2'h0)
        else $error("status read did not clear");
    result_take_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        RESULT_VALID_I |=> s_r.result == $past(RESULT_DATA_I) && s_r.unread
        && s_r.status[cgc_pkg::ST_DONE_BIT])
        else $error("new result not captured");

    // outside low-power mode every divided tick reaches the converter
    conv_pass_a: assert property (
        @(posedge SYS_CLK_I) disable iff (!NRST_I)
        !s_r.lp && div_tick |=> conv_tick_r)
        else $error("divided tick not passed on");

    ovf_cover_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) OVERFLOW_IRQ_O);
    irq_cover_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) IRQ_O);
    lp_cover_c:  cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I) s_r.lp && conv_tick_r);
    div48_cover_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_r.ctl[11:9] == 3'h3 && div_tick);
    sub_src_cover_c: cover property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        s_r.ctl[5:4] == 2'h1 && div_tick);

endmodule : cgc_top

/* dv/cgc_analog_model.sv */
// analog side model: source clock levels and conversion result pulses
// assumes the system clock; fire_i asks for one result
`timescale 1ns/1ps
module cgc_analog_model
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        fire_i,
    output logic             sub_clk_o,
    output logic             aux_clk_o,
    output logic             tmr_clk_o,
    output logic             res_vld_o,
    output logic [15:0]      res_dat_o
);
    logic [3:0]  div_r;
    logic [15:0] cnt_r;

    // periods 4, 8 and 16 cycles, all below half the system clock
    assign sub_clk_o = div_r[1];
    assign aux_clk_o = div_r[2];
    assign tmr_clk_o = div_r[3];

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            div_r     <= 4'h0;
            cnt_r     <= 16'h1000;
            res_vld_o <= 1'b0;
            res_dat_o <= 16'h0000;
        end
        else
        begin
            div_r     <= div_r + 4'h1;
            res_vld_o <= fire_i;
            // data is only meaningful with the strobe, so it churns otherwise
            res_dat_o <= fire_i ? cnt_r : ~res_dat_o;
            if (fire_i)
                cnt_r <= cnt_r + 16'h1;
        end
    end
endmodule : cgc_analog_model

/* dv/tb.sv */
// testbench for the converter global control block
// assumes a one-cycle wishbone answer may take longer; waits are bounded
`timescale 1ns/1ps
module tb;
    logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'hf;
    logic [31:0] wdat = 32'h0, rdat;
    logic        ack, sub, aux, tmr, global_irq_enable = 1'b0, fire = 1'b0, vld, tick;
    logic        lp, mid, rf, ovf, irq;
    logic [15:0] rdata;
    int          mismatches = 0, cmp_count = 0;
    int          xr[5] = '{1, 3, 16, 48, 1};
    int          sp[4] = '{1, 4, 8, 16};
    int          bp[3] = '{8, 3, 2};

    initial forever #2 clk = ~clk;

    cgc_analog_model i_cgc_analog_model (.clk_i(clk), .nrst_i(nrst), .fire_i(fire), .sub_clk_o(sub),
        .aux_clk_o(aux), .tmr_clk_o(tmr), .res_vld_o(vld), .res_dat_o(rdata));

    cgc_top i_cgc_top (.SYS_CLK_I(clk), .NRST_I(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .SUB_MAIN_CLOCK_I(sub), .AUX_CLOCK_I(aux), .TIMER_EXTERNAL_CLOCK_IN_I(tmr),
        .GLOBAL_IRQ_ENABLE_I(global_irq_enable), .RESULT_VALID_I(vld), .RESULT_DATA_I(rdata), .CONV_CLK_TICK_O(tick),
        .LOW_POWER_SELECT_O(lp), .MIDSUPPLY_BUFFER_ON_O(mid), .REFERENCE_GENERATOR_ON_O(rf),
        .OVERFLOW_IRQ_O(ovf), .IRQ_O(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (n >= 20)
            mismatches++;
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        wb(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask : rdc

    // first interval after a setting change may be short, so measure the second
    task automatic per(input int e);
        int n;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            do
            begin
                @(posedge clk);
                n++;
            end
            while (tick !== 1'b1 && n < 1600);
        end
        chk(32'(n), 32'(e));
    endtask : per

    task automatic shot;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : shot

    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rdc(cgc_pkg::CTL_ADDR, 32'h0);
        rdc(cgc_pkg::MASK_ADDR, 32'h0);
        chk({27'h0, lp, mid, rf, ovf, irq}, 32'h0);
        wr(cgc_pkg::CTL_ADDR, 32'hffff_ffff);
        rdc(cgc_pkg::CTL_ADDR, 32'h0ffe);
        for (int i = 0; i < 3; i++)
        begin
            wr(cgc_pkg::CTL_ADDR, 32'h1 << bp[i]);
            chk({29'h0, lp, mid, rf}, 32'h4 >> i);
        end
        $display("test register done");
        for (int p = 0; p < 4; p++)
            for (int x = 0; x < 5; x++)
            begin
                wr(cgc_pkg::CTL_ADDR, {20'h0, 3'(x), 1'b0, 2'(p), 6'h0});
                per((1 << p) * xr[x]);
            end
        for (int s = 1; s < 4; s++)
        begin
            wr(cgc_pkg::CTL_ADDR, {24'h0, 2'h1, 2'(s), 4'h0});
            per(2 * sp[s]);
        end
        // low power is a further halving of the tick rate
        wr(cgc_pkg::CTL_ADDR, 32'h0340);
        per(12);
        $display("test clock done");
        wr(cgc_pkg::MASK_ADDR, 32'h3);
        wr(cgc_pkg::CTL_ADDR, 32'h2);
        global_irq_enable <= 1'b1;
        shot();
        chk({30'h0, ovf, irq}, 32'h1);
        rdc(cgc_pkg::RESULT_ADDR, 32'h1000);
        shot();
        rdc(cgc_pkg::STATUS_ADDR, 32'h1);
        chk({31'h0, irq}, 32'h0);
        shot();
        chk({31'h0, ovf}, 32'h1);
        global_irq_enable <= 1'b0;
        repeat (2) @(posedge clk);
        chk({31'h0, ovf}, 32'h0);
        global_irq_enable <= 1'b1;
        wr(cgc_pkg::CTL_ADDR, 32'h0);
        chk({31'h0, ovf}, 32'h0);
        rdc(cgc_pkg::RESULT_ADDR, 32'h1002);
        rdc(cgc_pkg::STATUS_ADDR, 32'h3);
        chk({31'h0, irq}, 32'h0);
        wr(cgc_pkg::MASK_ADDR, 32'h0);
        shot();
        chk({31'h0, irq}, 32'h0);
        rdc(cgc_pkg::STATUS_ADDR, 32'h1);
        wr(8'h10, 32'hffff_ffff);
        rdc(8'h10, 32'h0);
        rdc(cgc_pkg::CTL_ADDR, 32'h0);
        sel <= 4'h1;
        wr(cgc_pkg::CTL_ADDR, 32'hffff);
        sel <= 4'hf;
        rdc(cgc_pkg::CTL_ADDR, 32'h00fe);
        $display("test irq done");
        wr(cgc_pkg::CTL_ADDR, 32'h0ffe);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rdc(cgc_pkg::CTL_ADDR, 32'h0);
        chk({29'h0, lp, mid, rf}, 32'h0);
        $display("test reset done");
        end_of_test();
    end
endmodule : tb
